// [inc/lso_pkg.sv]
// Overview of operation
// - Crystal oscillator keeps running across non-power-on resets when run_on_request is 0.
// - Crystal start-up waits a time_sel_a chosen count with its output gated off.
// - Crystal ready status goes to 1 once start-up has completed.
// - Crystal ready rising edge raises an interrupt when its enable is 1.
// - Internal oscillator is off after reset; its enable bit starts and stops it.
// - A new freq_trim value is committed only when internal ready goes high.
// - Internal 32.768kHz output runs only while out_32k_enable is 1.
// - Internal 1.024kHz output runs only while out_1k_enable is 1.
// - Internal oscillator with enable 0 stays stopped in every mode.
// - In standby the crystal runs only on request unless run_in_standby without request mode.
// - Flag bit 1 sets on internal ready rising, interrupts when enabled.
// - Flag bit 0 sets on crystal ready rising, interrupts when enabled.
// - Writing 1 clears a ready flag; writing 0 leaves it.
package lso_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_IRQ_EN_CLR  = 12'h000;
  localparam logic [11:0] OFS_IRQ_EN_SET  = 12'h004;
  localparam logic [11:0] OFS_IRQ_FLAG    = 12'h008;
  localparam logic [11:0] OFS_STATUS      = 12'h00c;
  localparam logic [11:0] OFS_EXT_CONTROL = 12'h010;
  localparam logic [11:0] OFS_INT_CONTROL = 12'h014;
  // Field positions
  localparam int BIT_EXT_RDY = 0;
  localparam int BIT_INT_RDY = 1;
  localparam int BIT_EN      = 1;
  localparam int BIT_O32     = 2;
  localparam int BIT_O1      = 3;
  localparam int BIT_RSB     = 6;
  localparam int BIT_ROR     = 7;
  localparam int BIT_TSEL    = 8;
  localparam int BIT_TRIM    = 16;
  // Reset values
  localparam logic [6:0]  TRIM_RST = 7'h40;
  localparam logic [2:0]  TSEL_RST = 3'h0;
  // Start-up counts in pclk cycles
  localparam logic [11:0] EXT_START_BASE = 12'h010;
  localparam logic [11:0] INT_START_CYC  = 12'h020;

  typedef enum logic [1:0] {
    OSC_OFF   = 2'b00,
    OSC_START = 2'b01,
    OSC_READY = 2'b11
  } lso_osc_st_t;

  typedef struct packed {
    logic en;
    logic o32;
    logic o1;
    logic rsb;
    logic ror;
  } lso_cfg_t;

  typedef struct packed {
    lso_osc_st_t st;
    logic [11:0] cnt;
  } lso_osc_t;
endpackage : lso_pkg

// [rtl/lso_ctrl.sv]
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
module lso_ctrl
  import lso_pkg::*;
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // System and sleep
  input  wire logic        soft_reset,
  input  wire logic        standby,
  input  wire logic        ext_req,
  input  wire logic        int_req,
  // Oscillator controls
  output logic             ext_osc_run,
  output logic             int_osc_run,
  output logic [6:0]       freq_trim_out,
  output logic             ext_out_32k,
  output logic             ext_out_1k,
  output logic             int_out_32k,
  output logic             int_out_1k,
  // Interrupt
  output logic             irq
);

  typedef struct packed {
    lso_cfg_t    ext_cfg;
    logic [2:0]  tsel;
    lso_cfg_t    int_cfg;
    logic [6:0]  trim_wr;
    logic [6:0]  trim_app;
    logic        trim_pend;
    lso_osc_t    ext_o;
    lso_osc_t    int_o;
    logic        ext_rdy_d;
    logic        int_rdy_d;
    logic [1:0]  flag;
    logic [1:0]  ien;
    logic        rdy;
    logic        err;
    logic [31:0] rdata;
    logic        ext_run;
    logic        int_run;
    logic        e32;
    logic        e1;
    logic        i32;
    logic        i1;
    logic        irq;
  } lso_st_t;

  lso_st_t s_reg;
  lso_st_t s_next;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic run_cond(input lso_cfg_t c, input logic sb,
                                    input logic req);
    logic r;
    r = 1'b0;
    if (!c.en) begin
      r = 1'b0;
    end else if (sb) begin
      r = (c.rsb && !c.ror) ? 1'b1 : req;
    end else begin
      r = c.ror ? req : 1'b1;
    end
    return r;
  endfunction : run_cond

  // Restart in ready forces a fresh start-up with output masked
  function automatic lso_osc_t osc_step(input lso_osc_t o, input logic run,
                                        input logic restart,
                                        input logic [11:0] lim);
    lso_osc_t n;
    n = o;
    if (!run) begin
      n.st  = OSC_OFF;
      n.cnt = 12'h000;
    end else begin
      case (o.st)
        OSC_OFF: begin
          n.st  = OSC_START;
          n.cnt = 12'h000;
        end
        OSC_START: begin
          if (o.cnt >= lim - 12'h001) begin
            n.st = OSC_READY;
          end else begin
            n.cnt = o.cnt + 12'h001;
          end
        end
        OSC_READY: begin
          if (restart) begin
            n.st  = OSC_START;
            n.cnt = 12'h000;
          end
        end
        default: begin
          n.st  = OSC_OFF;
          n.cnt = 12'h000;
        end
      endcase
    end
    return n;
  endfunction : osc_step

  ////////////////////////////////////////////////////////////////////
  // Next state

  logic        acc;
  logic        wr;
  logic [31:0] rd;
  logic        hit;
  logic        e_run;
  logic        i_run;
  logic        e_rdy;
  logic        i_rdy;
  logic [1:0]  rise;
  logic [11:0] ext_lim;
  logic        trim_wr_now;

  always_comb begin
    s_next      = s_reg;
    acc         = psel && penable;
    wr          = acc && pwrite && s_reg.rdy;
    rd          = 32'h0000_0000;
    hit         = 1'b1;
    trim_wr_now = 1'b0;

    // Read mux, unmapped words answer with error
    case (paddr)
      OFS_IRQ_EN_CLR:  rd[1:0] = s_reg.ien;
      OFS_IRQ_EN_SET:  rd[1:0] = s_reg.ien;
      OFS_IRQ_FLAG:    rd[1:0] = s_reg.flag;
      OFS_STATUS: begin
        rd[BIT_EXT_RDY] = s_reg.ext_o.st == OSC_READY;
        rd[BIT_INT_RDY] = s_reg.int_o.st == OSC_READY;
      end
      OFS_EXT_CONTROL: begin
        rd[BIT_EN]                  = s_reg.ext_cfg.en;
        rd[BIT_O32]                 = s_reg.ext_cfg.o32;
        rd[BIT_O1]                  = s_reg.ext_cfg.o1;
        rd[BIT_RSB]                 = s_reg.ext_cfg.rsb;
        rd[BIT_ROR]                 = s_reg.ext_cfg.ror;
        rd[BIT_TSEL+2:BIT_TSEL]     = s_reg.tsel;
      end
      OFS_INT_CONTROL: begin
        rd[BIT_EN]                  = s_reg.int_cfg.en;
        rd[BIT_O32]                 = s_reg.int_cfg.o32;
        rd[BIT_O1]                  = s_reg.int_cfg.o1;
        rd[BIT_RSB]                 = s_reg.int_cfg.rsb;
        rd[BIT_ROR]                 = s_reg.int_cfg.ror;
        rd[BIT_TRIM+6:BIT_TRIM]     = s_reg.trim_wr;
      end
      default: hit = 1'b0;
    endcase

    // One wait state: pready rises one cycle into the access phase
    if (acc && !s_reg.rdy) begin
      s_next.rdy   = 1'b1;
      s_next.err   = !hit;
      s_next.rdata = pwrite ? 32'h0000_0000 : rd;
    end else begin
      s_next.rdy   = 1'b0;
      s_next.err   = 1'b0;
      s_next.rdata = 32'h0000_0000;
    end

    // Register writes
    if (wr && hit) begin
      case (paddr)
        OFS_IRQ_EN_CLR: s_next.ien = s_reg.ien & ~pwdata[1:0];
        OFS_IRQ_EN_SET: s_next.ien = s_reg.ien | pwdata[1:0];
        OFS_EXT_CONTROL: begin
          s_next.ext_cfg.en  = pwdata[BIT_EN];
          s_next.ext_cfg.o32 = pwdata[BIT_O32];
          s_next.ext_cfg.o1  = pwdata[BIT_O1];
          s_next.ext_cfg.rsb = pwdata[BIT_RSB];
          s_next.ext_cfg.ror = pwdata[BIT_ROR];
          s_next.tsel        = pwdata[BIT_TSEL+2:BIT_TSEL];
        end
        OFS_INT_CONTROL: begin
          s_next.int_cfg.en  = pwdata[BIT_EN];
          s_next.int_cfg.o32 = pwdata[BIT_O32];
          s_next.int_cfg.o1  = pwdata[BIT_O1];
          s_next.int_cfg.rsb = pwdata[BIT_RSB];
          s_next.int_cfg.ror = pwdata[BIT_ROR];
          if (pwdata[BIT_TRIM+6:BIT_TRIM] != s_reg.trim_wr) begin
            trim_wr_now = 1'b1;
          end
          s_next.trim_wr     = pwdata[BIT_TRIM+6:BIT_TRIM];
        end
        default: ;
      endcase
    end

    // Oscillator sequencing
    ext_lim = EXT_START_BASE << s_reg.tsel;
    e_run   = run_cond(s_reg.ext_cfg, standby, ext_req);
    i_run   = run_cond(s_reg.int_cfg, standby, int_req);
    s_next.ext_o = osc_step(s_reg.ext_o, e_run, 1'b0, ext_lim);
    s_next.int_o = osc_step(s_reg.int_o, i_run, trim_wr_now,
                            INT_START_CYC);
    if (trim_wr_now) begin
      s_next.trim_pend = 1'b1;
    end

    e_rdy = s_next.ext_o.st == OSC_READY;
    i_rdy = s_next.int_o.st == OSC_READY;

    // Trim lands on the analog side only at the ready edge
    if (i_rdy && !s_reg.int_rdy_d && s_reg.trim_pend) begin
      s_next.trim_app  = s_reg.trim_wr;
      s_next.trim_pend = trim_wr_now;
    end

    // Sticky flags, a set in the clearing cycle wins
    rise[BIT_EXT_RDY] = e_rdy && !s_reg.ext_rdy_d;
    rise[BIT_INT_RDY] = i_rdy && !s_reg.int_rdy_d;
    if (wr && paddr == OFS_IRQ_FLAG) begin
      s_next.flag = s_reg.flag & ~pwdata[1:0];
    end
    s_next.flag      = s_next.flag | rise;
    s_next.ext_rdy_d = e_rdy;
    s_next.int_rdy_d = i_rdy;

    // Non-power-on reset: crystal kept alive only without on-request
    if (soft_reset) begin
      s_next.int_cfg   = '0;
      s_next.trim_wr   = TRIM_RST;
      s_next.trim_app  = TRIM_RST;
      s_next.trim_pend = 1'b0;
      s_next.int_o     = '{st: OSC_OFF, cnt: 12'h000};
      s_next.int_rdy_d = 1'b0;
      s_next.flag      = '0;
      s_next.ien       = '0;
      if (s_reg.ext_cfg.ror) begin
        s_next.ext_cfg   = '0;
        s_next.tsel      = TSEL_RST;
        s_next.ext_o     = '{st: OSC_OFF, cnt: 12'h000};
        s_next.ext_rdy_d = 1'b0;
      end else begin
        // Crystal state held across the reset
        s_next.ext_cfg   = s_reg.ext_cfg;
        s_next.tsel      = s_reg.tsel;
      end
    end

    // Outputs, outputs gated until ready
    s_next.ext_run = s_next.ext_o.st != OSC_OFF;
    s_next.int_run = s_next.int_o.st != OSC_OFF;
    s_next.e32 = s_next.ext_cfg.o32 && s_next.ext_o.st == OSC_READY;
    s_next.e1  = s_next.ext_cfg.o1 && s_next.ext_o.st == OSC_READY;
    s_next.i32 = s_next.int_cfg.o32 && s_next.int_o.st == OSC_READY;
    s_next.i1  = s_next.int_cfg.o1 && s_next.int_o.st == OSC_READY;
    s_next.irq = |(s_next.flag & s_next.ien);
  end

  ////////////////////////////////////////////////////////////////////
  // State register, power-on reset only

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{
        ext_cfg:   '0,
        tsel:      TSEL_RST,
        int_cfg:   '0,
        trim_wr:   TRIM_RST,
        trim_app:  TRIM_RST,
        trim_pend: 1'b0,
        ext_o:     '{st: OSC_OFF, cnt: 12'h000},
        int_o:     '{st: OSC_OFF, cnt: 12'h000},
        ext_rdy_d: 1'b0,
        int_rdy_d: 1'b0,
        flag:      2'h0,
        ien:       2'h0,
        rdy:       1'b0,
        err:       1'b0,
        rdata:     32'h0000_0000,
        ext_run:   1'b0,
        int_run:   1'b0,
        e32:       1'b0,
        e1:        1'b0,
        i32:       1'b0,
        i1:        1'b0,
        irq:       1'b0
      };
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Ports

  assign prdata        = s_reg.rdata;
  assign pready        = s_reg.rdy;
  assign pslverr       = s_reg.err;
  assign ext_osc_run   = s_reg.ext_run;
  assign int_osc_run   = s_reg.int_run;
  assign freq_trim_out = s_reg.trim_app;
  assign ext_out_32k   = s_reg.e32;
  assign ext_out_1k    = s_reg.e1;
  assign int_out_32k   = s_reg.i32;
  assign int_out_1k    = s_reg.i1;
  assign irq           = s_reg.irq;

endmodule : lso_ctrl

// [bench/lso_ctrl_sva.sv]
`timescale 1ns/1ps
module lso_ctrl_chk
  import lso_pkg::*;
(
  // APB side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Modes and oscillators
  input wire logic        soft_reset,
  input wire logic        standby,
  input wire logic        ext_osc_run,
  input wire logic        int_osc_run,
  input wire logic [6:0]  freq_trim_out,
  input wire logic        ext_out_32k,
  input wire logic        ext_out_1k,
  input wire logic        int_out_32k,
  input wire logic        int_out_1k,
  input wire logic        irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_wr;
    psel && penable && pready && pwrite && !soft_reset;
  endsequence
  sequence s_int_on;
    s_wr ##0 paddr == OFS_INT_CONTROL && pwdata[BIT_EN] && !pwdata[BIT_ROR] && !standby;
  endsequence
  sequence s_int_off;
    s_wr ##0 paddr == OFS_INT_CONTROL && !pwdata[BIT_EN];
  endsequence
  sequence s_mask_all;
    s_wr ##0 paddr == OFS_IRQ_EN_CLR && pwdata[1:0] == 2'b11;
  endsequence
  AST_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("no ready in second access cycle");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_RD_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  AST_INT_ON: assert property (s_int_on |-> ##[1:2] int_osc_run)
    else $error("internal osc not started");
  AST_INT_OFF: assert property (s_int_off |-> ##[1:2] !int_osc_run)
    else $error("internal osc not stopped");
  AST_INT_MASK: assert property ($rose(int_osc_run) |-> (!int_out_32k && !int_out_1k)[*8])
    else $error("internal output during start-up");
  AST_INT_GATE: assert property (!int_osc_run |-> !int_out_32k && !int_out_1k)
    else $error("internal output while stopped");
  AST_EXT_MASK: assert property ($rose(ext_osc_run) |-> (!ext_out_32k && !ext_out_1k)[*8])
    else $error("crystal output during start-up");
  AST_IRQ_MASK: assert property (s_mask_all |-> ##[1:2] !irq)
    else $error("irq with all enables cleared");
  AST_TRIM: assert property ($changed(freq_trim_out) |-> int_osc_run || $past(soft_reset))
    else $error("trim committed while stopped");
endmodule : lso_ctrl_chk

// [bench/lso_consumer.sv]
`timescale 1ns/1ps
module lso_consumer
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Demand from the bench, answer lag of lag+1 cycles
  input  wire logic       use_ext,
  input  wire logic       use_int,
  input  wire logic [1:0] lag,
  // Requests to the controller
  output logic            ext_req,
  output logic            int_req
);
  logic [3:0] ext_sr;
  logic [3:0] int_sr;
  // Bench raises use_ext only after the crystal output is enabled, and use_int while the internal osc is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sr <= 4'h0;
      int_sr <= 4'h0;
    end else begin
      ext_sr <= {ext_sr[2:0], use_ext};
      int_sr <= {int_sr[2:0], use_int};
    end
  end
  assign ext_req = ext_sr[lag];
  assign int_req = int_sr[lag];
endmodule : lso_consumer

// [bench/lso_ctrl_bench.sv]
`timescale 1ns/1ps
module lso_ctrl_bench
  import lso_pkg::*;
;
  localparam logic [31:0] C_EN = 32'h1 << BIT_EN;
  localparam logic [31:0] C_32 = 32'h1 << BIT_O32;
  localparam logic [31:0] C_1K = 32'h1 << BIT_O1;
  localparam logic [31:0] C_SB = (32'h1 << BIT_RSB) | (32'h1 << BIT_ROR);
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, soft_reset, standby;
  logic        ext_req, int_req, use_ext, use_int, irq;
  logic        ext_osc_run, int_osc_run, ext_out_32k, ext_out_1k, int_out_32k, int_out_1k;
  logic [1:0]  lag;
  logic [2:0]  tsel;
  logic [6:0]  freq_trim_out, t;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [32:0] exp_q[$];
  int          num_errors, tests_run, n;
  lso_ctrl lso_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .soft_reset(soft_reset), .standby(standby), .ext_req(ext_req),
    .int_req(int_req), .ext_osc_run(ext_osc_run), .int_osc_run(int_osc_run),
    .freq_trim_out(freq_trim_out), .ext_out_32k(ext_out_32k), .ext_out_1k(ext_out_1k),
    .int_out_32k(int_out_32k), .int_out_1k(int_out_1k), .irq(irq));
  lso_consumer lso_consumer_inst (.pclk(pclk), .presetn(presetn), .use_ext(use_ext),
    .use_int(use_int), .lag(lag), .ext_req(ext_req), .int_req(int_req));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Extra idle edge so back-to-back calls never drive psel twice in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      num_errors++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic er = 1'b0);
    exp_q.push_back({er, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_hi(input logic sel_ext);
    n = 0;
    while ((sel_ext ? ext_out_32k : int_out_32k) !== 1'b1) begin
      @(posedge pclk);
      n++;
      if (n > 2200) begin
        num_errors++;
        test_done();
      end
    end
  endtask : wait_hi
  always @(posedge pclk) begin : mon
    logic [32:0] e;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      e = exp_q.pop_front();
      check(prdata, e[31:0]);
      check({31'h0, pslverr}, {31'h0, e[32]});
    end
  end
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, soft_reset, standby, use_ext, use_int} = 8'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    void'($urandom(32'he9a2));
    lag = 2'($urandom());
    t = 7'($urandom());
    tsel = 3'($urandom() % 3);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({25'h0, freq_trim_out}, {25'h0, TRIM_RST});
    rd(OFS_INT_CONTROL, {9'h0, TRIM_RST, 16'h0});
    rd(OFS_STATUS, 32'h0);
    rd(12'h020, 32'h0, 1'b1);
    // Internal osc with new trim, both outputs
    apb(1'b1, OFS_IRQ_EN_SET, 32'h3);
    apb(1'b1, OFS_INT_CONTROL, C_EN | C_32 | C_1K | {9'h0, t, 16'h0});
    wait_hi(1'b0);
    check({31'h0, int_out_1k}, 32'h1);
    check({31'h0, irq}, 32'h1);
    check({25'h0, freq_trim_out}, {25'h0, t});
    rd(OFS_STATUS, 32'h2);
    // Trim change holds the old value until ready again
    apb(1'b1, OFS_INT_CONTROL, C_EN | C_32 | {9'h0, t ^ 7'h55, 16'h0});
    repeat (2) @(posedge pclk);
    check({25'h0, freq_trim_out}, {25'h0, t});
    check({31'h0, int_out_1k}, 32'h0);
    wait_hi(1'b0);
    check({25'h0, freq_trim_out}, {25'h0, t ^ 7'h55});
    apb(1'b1, OFS_IRQ_FLAG, 32'h0);
    rd(OFS_IRQ_FLAG, 32'h2);
    apb(1'b1, OFS_IRQ_FLAG, 32'h2);
    rd(OFS_IRQ_FLAG, 32'h0);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_INT_CONTROL, 32'h0);
    // Run drops one edge after the disabling write lands
    @(posedge pclk);
    check({31'h0, int_osc_run | int_out_32k}, 32'h0);
    // Crystal start-up of 16 << tsel cycles
    apb(1'b1, OFS_EXT_CONTROL, C_EN | C_32 | C_1K | {21'h0, tsel, 8'h0});
    wait_hi(1'b1);
    // Ready is seen one edge after it is set, hence the extra cycle
    check(32'(n), {20'h0, EXT_START_BASE << tsel} + 32'h1);
    check({31'h0, ext_out_1k}, 32'h1);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_IRQ_EN_CLR, 32'h3);
    check({31'h0, irq}, 32'h0);
    rd(OFS_IRQ_FLAG, 32'h1);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    repeat (2) @(posedge pclk);
    check({31'h0, ext_osc_run}, 32'h1);
    rd(OFS_IRQ_FLAG, 32'h0);
    // Standby: crystal only on request, stopped internal osc ignores request
    apb(1'b1, OFS_EXT_CONTROL, C_EN | C_32 | C_SB);
    standby <= 1'b1;
    use_int <= 1'b1;
    repeat (6) @(posedge pclk);
    check({31'h0, ext_osc_run}, 32'h0);
    check({31'h0, int_osc_run}, 32'h0);
    use_ext <= 1'b1;
    repeat (6) @(posedge pclk);
    check({31'h0, ext_osc_run}, 32'h1);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    repeat (2) @(posedge pclk);
    check({31'h0, ext_osc_run}, 32'h0);
    test_done();
  end
endmodule : lso_ctrl_bench
bind lso_ctrl lso_ctrl_chk lso_ctrl_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .soft_reset(soft_reset), .standby(standby),
  .ext_osc_run(ext_osc_run), .int_osc_run(int_osc_run), .freq_trim_out(freq_trim_out),
  .ext_out_32k(ext_out_32k), .ext_out_1k(ext_out_1k), .int_out_32k(int_out_32k),
  .int_out_1k(int_out_1k), .irq(irq));
